/* common/calib_pkg.sv */
package calib_pkg;

  // ****************************************
  // register bus
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_ARG = 8'h04;
  localparam logic [7:0] A_VAL = 8'h08;
  localparam logic [7:0] A_RESULT = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_IRQ_STAT = 8'h14;
  localparam logic [7:0] A_IRQ_CLR = 8'h18;
  localparam logic [7:0] A_IRQ_EN = 8'h1C;
  localparam logic [7:0] A_REPORT = 8'h20;
  localparam logic [7:0] A_BRIGHT = 8'h24;

  // ****************************************
  // commands
  // ****************************************
  localparam int OP_W = 4;
  localparam logic [3:0] OP_GET_OFS = 4'h1;
  localparam logic [3:0] OP_SET_OFS = 4'h2;
  localparam logic [3:0] OP_PIX2CH = 4'h3;
  localparam logic [3:0] OP_STORE = 4'h4;
  localparam logic [3:0] OP_CLR_FF = 4'h5;
  localparam logic [3:0] OP_LIGHT_OFF = 4'h6;
  localparam logic [3:0] OP_LIGHT_ON = 4'h7;
  localparam logic [3:0] OP_RUN_FF = 4'h8;
  localparam logic [3:0] OP_SAVE_FF = 4'h9;
  localparam logic [3:0] OP_FREE_RUN = 4'hA;

  // ****************************************
  // fields and values
  // ****************************************
  localparam int ARG_W = 16;
  localparam int OFS_W = 10;
  localparam logic [9:0] OFS_MAX = 10'h200;
  localparam logic [15:0] BCAST_CH = 16'h03E7;
  localparam logic [9:0] OFS_RESET = 10'h000;
  localparam int PIX_W = 8;
  localparam logic [7:0] BRIGHT_RESET = 8'hE6;
  localparam int GAIN_W = 10;
  localparam logic [9:0] GAIN_ONE = 10'h100;
  localparam logic [9:0] GAIN_MAX = 10'h200;
  localparam int ST_BUSY = 0;
  localparam int ST_LIGHT = 1;
  localparam int ST_FF_VALID = 2;
  localparam int ST_FREE_RUN = 3;
  localparam int REP_VALID = 31;
  localparam int REP_CH_LSB = 16;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_FF = 2;

  typedef enum logic [6:0] {
    S_FILL = 7'b0000001,
    S_IDLE = 7'b0000010,
    S_LIST = 7'b0000100,
    S_LHOLD = 7'b0001000,
    S_STORE = 7'b0010000,
    S_FF_RUN = 7'b0100000,
    S_FF_SAVE = 7'b1000000
  } fsm_t;

endpackage

/* verilog/ofs_mem.sv */
`timescale 1ns/1ps
module ofs_mem #(
  parameter int DEPTH = 8,
  parameter int W = 10,
  parameter int AW = 3
) (
  // clock
  input wire logic mclk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2 || (1 << AW) < DEPTH) $error("ofs_mem: bad depth");
  end

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

/* verilog/calib_offset_cmd_interp.sv */
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - get-offset lists every channel with its offset
// - set-offset writes value to named channel
// - channel 999 writes value to all channels
// - offsets 0..512; low amplifies, high attenuates
// - channel numbering starts at zero
// - pixel query returns its serving channel
// - store writes offsets to permanent memory
// - clear-correction drops gains, output uncorrected
// - lighting off and on commands
// - run correction, then signal finished status
// - save-correction writes gains to permanent memory
// - gain only raises, max two; bright pixels kept
module calib_offset_cmd_interp
  import calib_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int PIX_PER_CH_LOG2 = 9
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // interrupt
  output logic irq,
  // offset store to permanent memory
  output logic nvm_wr_valid,
  output logic [ARG_W-1:0] nvm_wr_addr,
  output logic [OFS_W-1:0] nvm_wr_data,
  output logic nvm_commit,
  // flat-field engine
  output logic run_flat_field,
  input wire logic ff_done,
  output logic ff_save_req,
  input wire logic ff_save_done,
  output logic clear_flat_field,
  // sensor control
  output logic lighting,
  output logic free_running_operation,
  output logic [OFS_W-1:0] bright_target_level,
  // per-pixel gain limiter
  input wire logic [PIX_W-1:0] px_raw,
  input wire logic [GAIN_W-1:0] px_gain_in,
  output logic [GAIN_W-1:0] px_gain_out
);

  localparam int CH_W = $clog2(NUM_CH);
  localparam logic [CH_W-1:0] CH_LAST = CH_W'(NUM_CH - 1);

  initial begin
    if (NUM_CH < 2 || NUM_CH > 999) $error("calib: NUM_CH out of range");
    if (PIX_PER_CH_LOG2 < 1 || PIX_PER_CH_LOG2 > 15) $error("calib: bad pixel shift");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    fsm_t fsm;
    logic booting;
    logic pend;
    logic [CH_W-1:0] idx;
    logic [ARG_W-1:0] arg;
    logic [OFS_W-1:0] val;
    logic [ARG_W-1:0] result;
    logic [OFS_W-1:0] rep_ofs;
    logic [CH_W-1:0] rep_ch;
    logic rep_valid;
    logic light;
    logic ff_valid;
    logic free_run;
    logic [PIX_W-1:0] bright;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [DATA_W-1:0] rdata;
    logic nvm_wr_valid;
    logic [ARG_W-1:0] nvm_addr;
    logic [OFS_W-1:0] nvm_data;
    logic nvm_commit;
    logic ff_run;
    logic ff_save;
    logic [GAIN_W-1:0] gain;
  } state_t;

  state_t q_r;
  state_t q_nxt;
  logic mem_we;
  logic [CH_W-1:0] mem_waddr;
  logic [OFS_W-1:0] mem_wdata;
  logic mem_re;
  logic [OFS_W-1:0] mem_rdata;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [ARG_W-1:0] pix_ch;

  // ****************************************
  // offset memory
  // ****************************************
  ofs_mem #(
    .DEPTH(NUM_CH),
    .W(OFS_W),
    .AW(CH_W)
  ) u_mem (
    .mclk(mclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .re(mem_re),
    .raddr(q_r.idx),
    .rdata(mem_rdata)
  );

  assign pix_ch = q_r.arg >> PIX_PER_CH_LOG2;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.nvm_wr_valid = 1'b0;
    q_nxt.nvm_commit = 1'b0;
    q_nxt.ff_run = 1'b0;
    q_nxt.ff_save = 1'b0;
    q_nxt.rdata = '0;
    ev = '0;
    clr = '0;
    mem_we = 1'b0;
    mem_waddr = q_r.idx;
    mem_wdata = q_r.val;
    mem_re = 1'b0;

    // register writes and commands
    if (wr) begin
      case (addr)
        A_ARG: q_nxt.arg = wdata[ARG_W-1:0];
        A_VAL: q_nxt.val = wdata[OFS_W-1:0];
        A_BRIGHT: q_nxt.bright = wdata[PIX_W-1:0];
        A_IRQ_CLR: clr = wdata[IRQ_W-1:0];
        A_IRQ_EN: q_nxt.irq_en = wdata[IRQ_W-1:0];
        A_CMD: begin
          if (q_r.fsm != S_IDLE) begin
            ev[IRQ_ERR] = 1'b1;
          end else begin
            case (wdata[OP_W-1:0])
              OP_GET_OFS: begin
                q_nxt.idx = '0;
                q_nxt.pend = 1'b0;
                q_nxt.fsm = S_LIST;
              end
              OP_SET_OFS: begin
                if (q_r.val > OFS_MAX) begin
                  ev[IRQ_ERR] = 1'b1;
                end else if (q_r.arg == BCAST_CH) begin
                  q_nxt.idx = '0;
                  q_nxt.fsm = S_FILL;
                end else if (q_r.arg >= ARG_W'(NUM_CH)) begin
                  ev[IRQ_ERR] = 1'b1;
                end else begin
                  mem_we = 1'b1;
                  mem_waddr = q_r.arg[CH_W-1:0];
                  ev[IRQ_DONE] = 1'b1;
                end
              end
              OP_PIX2CH: begin
                if (pix_ch >= ARG_W'(NUM_CH)) begin
                  ev[IRQ_ERR] = 1'b1;
                end else begin
                  q_nxt.result = pix_ch;
                  ev[IRQ_DONE] = 1'b1;
                end
              end
              OP_STORE: begin
                q_nxt.idx = '0;
                q_nxt.pend = 1'b0;
                q_nxt.fsm = S_STORE;
              end
              OP_CLR_FF: begin
                q_nxt.ff_valid = 1'b0;
                ev[IRQ_DONE] = 1'b1;
              end
              OP_LIGHT_OFF: begin
                q_nxt.light = 1'b0;
                ev[IRQ_DONE] = 1'b1;
              end
              OP_LIGHT_ON: begin
                q_nxt.light = 1'b1;
                ev[IRQ_DONE] = 1'b1;
              end
              OP_RUN_FF: begin
                q_nxt.ff_run = 1'b1;
                q_nxt.fsm = S_FF_RUN;
              end
              OP_SAVE_FF: begin
                q_nxt.ff_save = 1'b1;
                q_nxt.fsm = S_FF_SAVE;
              end
              OP_FREE_RUN: begin
                q_nxt.free_run = 1'b1;
                ev[IRQ_DONE] = 1'b1;
              end
              default: begin
                ev[IRQ_ERR] = 1'b1;
              end
            endcase
          end
        end
        default: ;
      endcase
    end

    // sequencer
    case (q_r.fsm)
      S_FILL: begin
        mem_we = 1'b1;
        mem_waddr = q_r.idx;
        mem_wdata = q_r.val;
        if (q_r.idx == CH_LAST) begin
          q_nxt.fsm = S_IDLE;
          q_nxt.booting = 1'b0;
          ev[IRQ_DONE] = !q_r.booting;
        end else begin
          q_nxt.idx = q_r.idx + 1'b1;
        end
      end
      S_LIST: begin
        if (!q_r.pend) begin
          mem_re = 1'b1;
          q_nxt.pend = 1'b1;
        end else begin
          q_nxt.pend = 1'b0;
          q_nxt.rep_ofs = mem_rdata;
          q_nxt.rep_ch = q_r.idx;
          q_nxt.rep_valid = 1'b1;
          q_nxt.fsm = S_LHOLD;
        end
      end
      S_STORE: begin
        if (!q_r.pend) begin
          mem_re = 1'b1;
          q_nxt.pend = 1'b1;
        end else begin
          q_nxt.pend = 1'b0;
          q_nxt.nvm_wr_valid = 1'b1;
          q_nxt.nvm_addr = ARG_W'(q_r.idx);
          q_nxt.nvm_data = mem_rdata;
          if (q_r.idx == CH_LAST) begin
            q_nxt.nvm_commit = 1'b1;
            q_nxt.fsm = S_IDLE;
            ev[IRQ_DONE] = 1'b1;
          end else begin
            q_nxt.idx = q_r.idx + 1'b1;
          end
        end
      end
      S_FF_RUN: begin
        if (ff_done) begin
          q_nxt.ff_valid = 1'b1;
          ev[IRQ_FF] = 1'b1;
          q_nxt.fsm = S_IDLE;
        end
      end
      S_FF_SAVE: begin
        if (ff_save_done) begin
          ev[IRQ_DONE] = 1'b1;
          q_nxt.fsm = S_IDLE;
        end
      end
      S_IDLE, S_LHOLD: ;
      default: begin
        q_nxt.fsm = S_IDLE;
      end
    endcase

    // register reads
    if (rd) begin
      case (addr)
        A_ARG: q_nxt.rdata = DATA_W'(q_r.arg);
        A_VAL: q_nxt.rdata = DATA_W'(q_r.val);
        A_RESULT: q_nxt.rdata = DATA_W'(q_r.result);
        A_STATUS: begin
          q_nxt.rdata[ST_BUSY] = (q_r.fsm != S_IDLE);
          q_nxt.rdata[ST_LIGHT] = q_r.light;
          q_nxt.rdata[ST_FF_VALID] = q_r.ff_valid;
          q_nxt.rdata[ST_FREE_RUN] = q_r.free_run;
        end
        A_IRQ_STAT: q_nxt.rdata = DATA_W'(q_r.irq_stat);
        A_IRQ_EN: q_nxt.rdata = DATA_W'(q_r.irq_en);
        A_BRIGHT: q_nxt.rdata = DATA_W'(q_r.bright);
        A_REPORT: begin
          q_nxt.rdata[REP_VALID] = q_r.rep_valid;
          q_nxt.rdata[REP_CH_LSB +: CH_W] = q_r.rep_ch;
          q_nxt.rdata[OFS_W-1:0] = q_r.rep_ofs;
          if (q_r.rep_valid) begin
            q_nxt.rep_valid = 1'b0;
            if (q_r.idx == CH_LAST) begin
              q_nxt.fsm = S_IDLE;
              ev[IRQ_DONE] = 1'b1;
            end else begin
              q_nxt.idx = q_r.idx + 1'b1;
              q_nxt.fsm = S_LIST;
            end
          end
        end
        default: ;
      endcase
    end

    // sticky events, set beats clear
    q_nxt.irq_stat = (q_r.irq_stat & ~clr) | ev;

    // gain limiter
    if (!q_r.ff_valid || px_raw >= q_r.bright) begin
      q_nxt.gain = GAIN_ONE;
    end else if (px_gain_in < GAIN_ONE) begin
      q_nxt.gain = GAIN_ONE;
    end else if (px_gain_in > GAIN_MAX) begin
      q_nxt.gain = GAIN_MAX;
    end else begin
      q_nxt.gain = px_gain_in;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_r <= '0;
      q_r.fsm <= S_FILL;
      q_r.booting <= 1'b1;
      q_r.val <= OFS_RESET;
      q_r.light <= 1'b1;
      q_r.bright <= BRIGHT_RESET;
      q_r.gain <= GAIN_ONE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata = q_r.rdata;
  assign irq = |(q_r.irq_stat & q_r.irq_en);
  assign nvm_wr_valid = q_r.nvm_wr_valid;
  assign nvm_wr_addr = q_r.nvm_addr;
  assign nvm_wr_data = q_r.nvm_data;
  assign nvm_commit = q_r.nvm_commit;
  assign run_flat_field = q_r.ff_run;
  assign ff_save_req = q_r.ff_save;
  assign clear_flat_field = !q_r.ff_valid;
  assign lighting = q_r.light;
  assign free_running_operation = q_r.free_run;
  assign bright_target_level = OFS_W'(q_r.bright);
  assign px_gain_out = q_r.gain;

endmodule

/* tb/calib_offset_asserts.sv */
`timescale 1ns/1ps
module calib_offset_asserts
  import calib_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  // block outputs, engine answers and pixel input
  input wire logic nvm_wr_valid,
  input wire logic [ARG_W-1:0] nvm_wr_addr,
  input wire logic nvm_commit,
  input wire logic run_flat_field,
  input wire logic ff_done,
  input wire logic ff_save_req,
  input wire logic clear_flat_field,
  input wire logic lighting,
  input wire logic [OFS_W-1:0] bright_target_level,
  input wire logic [PIX_W-1:0] px_raw,
  input wire logic [GAIN_W-1:0] px_gain_out
);
  // ****
  // command and store sequences
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence cmd_s(logic [3:0] op);
    wr && addr == A_CMD && wdata[3:0] == op;
  endsequence
  sequence next_word_s;
    !nvm_wr_valid ##1 nvm_wr_valid && nvm_wr_addr == $past(nvm_wr_addr, 2) + 1;
  endsequence
  light_off_a: assert property (cmd_s(OP_LIGHT_OFF) |=> !lighting)
    else $error("lighting stayed on");
  light_on_a: assert property (cmd_s(OP_LIGHT_ON) |=> lighting)
    else $error("lighting stayed off");
  clear_cmd_a: assert property (cmd_s(OP_CLR_FF) |=> clear_flat_field)
    else $error("gains not dropped");
  run_start_a: assert property (
    run_flat_field |-> $past(wr && addr == A_CMD && wdata[3:0] == OP_RUN_FF))
    else $error("run pulse without command");
  ff_finish_a: assert property (ff_done |=> !clear_flat_field)
    else $error("gains not valid after finish");
  save_start_a: assert property (
    ff_save_req |-> $past(wr && addr == A_CMD && wdata[3:0] == OP_SAVE_FF))
    else $error("save pulse without command");
  gain_range_a: assert property (px_gain_out >= GAIN_ONE && px_gain_out <= GAIN_MAX)
    else $error("gain out of range");
  gain_bright_a: assert property (px_raw >= bright_target_level[7:0] |=> px_gain_out == GAIN_ONE)
    else $error("bright pixel changed");
  store_last_a: assert property (nvm_commit |-> nvm_wr_valid && nvm_wr_addr == NUM_CH - 1)
    else $error("commit not with last word");
  store_step_a: assert property (nvm_wr_valid && nvm_wr_addr < NUM_CH - 1 |=> next_word_s)
    else $error("store word order broken");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule

/* tb/ff_engine_model.sv */
`timescale 1ns/1ps
module ff_engine_model #(
  parameter int DELAY = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // requests
  input wire logic run_flat_field,
  input wire logic ff_save_req,
  // answers
  output logic ff_done,
  output logic ff_save_done
);
  int run_cnt;
  int save_cnt;
  // ****
  // engine timing
  // ****
  always_ff @(posedge mclk) begin
    if (rst) begin
      run_cnt <= 0;
      save_cnt <= 0;
      ff_done <= 1'b0;
      ff_save_done <= 1'b0;
    end else begin
      run_cnt <= run_flat_field ? DELAY : (run_cnt > 0 ? run_cnt - 1 : 0);
      save_cnt <= ff_save_req ? DELAY : (save_cnt > 0 ? save_cnt - 1 : 0);
      ff_done <= (run_cnt == 1);
      ff_save_done <= (save_cnt == 1);
    end
  end
endmodule

/* tb/calib_offset_cmd_interp_tb.sv */
`timescale 1ns/1ps
module calib_offset_cmd_interp_tb;
  import calib_pkg::*;
  localparam int NCH = 8;
  localparam logic [7:0] RAWS [4] = '{8'h10, 8'h10, 8'h10, 8'hF0};
  localparam logic [9:0] GINS [4] = '{10'h300, 10'h080, 10'h180, 10'h180};
  localparam logic [9:0] GOUTS [4] = '{10'h200, 10'h100, 10'h180, 10'h100};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [PIX_W-1:0] px_raw = 8'h10;
  logic [GAIN_W-1:0] px_gain_in = 10'h100;
  logic [DATA_W-1:0] rdata, seen;
  logic irq, nvm_wr_valid, nvm_commit, run_flat_field, ff_done, ff_save_req, ff_save_done;
  logic clear_flat_field, lighting, free_running_operation;
  logic [ARG_W-1:0] nvm_wr_addr;
  logic [OFS_W-1:0] nvm_wr_data, bright_target_level, ofs3;
  logic [GAIN_W-1:0] px_gain_out;
  int err_count = 0;
  int num_checks = 0;
  int words = 0;
  always #12.5 mclk = ~mclk;
  calib_offset_cmd_interp #(.NUM_CH(NCH)) calib_offset_cmd_interp_inst (.mclk(mclk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .nvm_wr_valid(nvm_wr_valid), .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data),
    .nvm_commit(nvm_commit), .run_flat_field(run_flat_field), .ff_done(ff_done),
    .ff_save_req(ff_save_req), .ff_save_done(ff_save_done), .clear_flat_field(clear_flat_field),
    .lighting(lighting), .free_running_operation(free_running_operation),
    .bright_target_level(bright_target_level), .px_raw(px_raw), .px_gain_in(px_gain_in),
    .px_gain_out(px_gain_out));
  ff_engine_model ff_engine_model_inst (.mclk(mclk), .rst(rst), .run_flat_field(run_flat_field),
    .ff_save_req(ff_save_req), .ff_done(ff_done), .ff_save_done(ff_save_done));
  always @(posedge mclk) begin
    if (nvm_wr_valid === 1'b1) begin
      words++;
      if (nvm_wr_addr === 16'h0003) ofs3 = nvm_wr_data;
    end
  end
  // ****
  // access tasks
  // ****
  task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    seen = rdata;
  endtask
  task automatic cmd(input logic [3:0] op);
    wreg(A_CMD, {28'h0, op});
    @(posedge mclk);
    #1;
  endtask
  task automatic setofs(input logic [15:0] ch, input logic [9:0] v);
    wreg(A_ARG, {16'h0, ch});
    wreg(A_VAL, {22'h0, v});
    cmd(OP_SET_OFS);
  endtask
  task automatic wait_st(input int b, input logic v);
    rreg(A_STATUS);
    for (int n = 0; n < 200 && seen[b] !== v; n++) rreg(A_STATUS);
    chk(seen[b], v);
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    #200000;
    err_count++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk(clear_flat_field, 1'b1);
    chk(bright_target_level, {2'h0, BRIGHT_RESET});
    wait_st(ST_BUSY, 1'b0);
    rreg(8'h3C);
    chk(seen, 32'h0);
    wreg(A_IRQ_EN, 32'h7);
    endt("reset");
    setofs(BCAST_CH, 10'h005);
    cmd(OP_FREE_RUN);
    chk(free_running_operation, 1'b0);
    rreg(A_IRQ_STAT);
    chk(seen[IRQ_ERR], 1'b1);
    wait_st(ST_BUSY, 1'b0);
    setofs(16'h0003, OFS_MAX);
    wreg(A_IRQ_CLR, 32'h7);
    chk(irq, 1'b0);
    setofs(16'h0002, 10'h201);
    rreg(A_IRQ_STAT);
    chk(seen[IRQ_ERR], 1'b1);
    chk(irq, 1'b1);
    wreg(A_IRQ_CLR, 32'h7);
    wreg(A_IRQ_EN, 32'h0);
    setofs(16'h0008, 10'h001);
    rreg(A_IRQ_STAT);
    chk(seen[IRQ_ERR], 1'b1);
    chk(irq, 1'b0);
    wreg(A_IRQ_EN, 32'h7);
    wreg(A_IRQ_CLR, 32'h7);
    endt("offset set");
    cmd(OP_GET_OFS);
    for (int i = 0; i < NCH; i++) begin
      rreg(A_REPORT);
      for (int n = 0; n < 20 && seen[REP_VALID] !== 1'b1; n++) rreg(A_REPORT);
      chk(seen[25:16], i);
      chk(seen[9:0], (i == 3) ? OFS_MAX : 10'h005);
    end
    wait_st(ST_BUSY, 1'b0);
    rreg(A_REPORT);
    chk(seen, {1'b0, 5'h0, 10'(NCH - 1), 6'h0, 10'h005});
    cmd(OP_STORE);
    wait_st(ST_BUSY, 1'b0);
    chk(words, NCH);
    chk(ofs3, OFS_MAX);
    wreg(A_ARG, 32'h607);
    cmd(OP_PIX2CH);
    rreg(A_RESULT);
    chk(seen[15:0], 16'h0003);
    endt("listing store pixel");
    cmd(OP_LIGHT_OFF);
    chk(lighting, 1'b0);
    rreg(A_STATUS);
    chk(seen[ST_LIGHT], 1'b0);
    cmd(OP_LIGHT_ON);
    chk(lighting, 1'b1);
    cmd(OP_FREE_RUN);
    chk(free_running_operation, 1'b1);
    cmd(OP_RUN_FF);
    wait_st(ST_FF_VALID, 1'b1);
    chk(clear_flat_field, 1'b0);
    rreg(A_IRQ_STAT);
    chk(seen[IRQ_FF], 1'b1);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      px_raw <= RAWS[k];
      px_gain_in <= GINS[k];
      @(posedge mclk);
      #1;
      chk(px_gain_out, GOUTS[k]);
    end
    cmd(OP_SAVE_FF);
    wait_st(ST_BUSY, 1'b0);
    cmd(OP_CLR_FF);
    chk(clear_flat_field, 1'b1);
    @(posedge mclk);
    px_raw <= 8'h10;
    px_gain_in <= 10'h180;
    @(posedge mclk);
    #1;
    chk(px_gain_out, GAIN_ONE);
    endt("lighting and correction");
    conclude;
  end
endmodule
bind calib_offset_cmd_interp calib_offset_asserts #(.NUM_CH(NUM_CH)) calib_offset_asserts_inst (
  .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .nvm_wr_valid(nvm_wr_valid), .nvm_wr_addr(nvm_wr_addr), .nvm_commit(nvm_commit),
  .run_flat_field(run_flat_field), .ff_done(ff_done), .ff_save_req(ff_save_req),
  .clear_flat_field(clear_flat_field), .lighting(lighting),
  .bright_target_level(bright_target_level), .px_raw(px_raw), .px_gain_out(px_gain_out));
